// File: rtl/weigh_cmd_regs.svh
// constants of the weigh command interpreter
`ifndef WEIGH_CMD_REGS_SVH
`define WEIGH_CMD_REGS_SVH

`define WCI_CLK_MHZ      10
`define WCI_TICK_US      1000
`define WCI_TIMER_W      16
`define WCI_TIMEOUT_RST  16'h0BB8
`define WCI_ERR_SUFFIX   8'h62
`define WCI_UNIT_CODE    2'h1
`define WCI_NO_UNIT      2'h0

`endif

// File: rtl/weigh_cmd_pkg.sv
// types of the weigh command interpreter
package weigh_cmd_pkg;

    typedef enum logic [4:0] {
        c_weight_stable,
        c_get_stable_or_dynamic,
        c_weight_now,
        c_repeat_weight_now,
        c_get_net_with_flags,
        c_repeat_next_stable,
        c_repeat_on_change,
        c_offset_stable,
        c_offset_memory_access,
        c_offset_memory_clear,
        c_timed_offset_capture,
        c_immediate_offset_capture,
        c_reference_stable,
        c_timed_reference_capture,
        c_immediate_reference_capture,
        c_general_timeout_setting,
        c_cancel
    } cmd_t;

    typedef enum logic [2:0] {
        k_ack,
        k_weight,
        k_error,
        k_abort,
        k_refused
    } resp_kind_t;

    typedef enum logic [1:0] {
        s_idle,
        s_wait,
        s_repeat
    } state_t;

endpackage

// File: rtl/weigh_command_interpreter.sv
// weigh command interpreter with its response fifo
`timescale 1ns/1ps
`default_nettype none
`include "weigh_cmd_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// shift-register fifo, head always in slot 0

module resp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [CW-1:0]         count
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;
    logic [CW-1:0]    wr_idx;
    logic [CW-1:0]    next_count;

    assign in_ready   = count != CW'(DEPTH);
    assign push       = in_valid && in_ready;
    assign pop        = out_valid && out_ready;
    assign wr_idx     = count - CW'(pop);
    assign next_count = count + CW'(push) - CW'(pop);
    assign out_data   = mem[0];

    always_ff @(posedge clk_sys)
    begin
        for (int i = 0; i < DEPTH - 1; i++)
        begin
            if (pop)
                mem[i] <= mem[i + 1];
        end
        for (int i = 0; i < DEPTH; i++)
        begin
            if (push && wr_idx == CW'(i))
                mem[i] <= in_data;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            count     <= '0;
            out_valid <= 1'b0;
        end
        else
        begin
            count     <= next_count;
            out_valid <= next_count != '0;
        end
    end
endmodule // resp_fifo

////////////////////////////////////////////////////////////////////////////////
// command interpreter

module weigh_command_interpreter #(
    parameter int W           = 24,
    parameter int DEPTH       = 4,
    parameter int TICK_CYCLES = `WCI_TICK_US * `WCI_CLK_MHZ
) (
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic         cmd_valid,
    output logic              cmd_ready,
    input  wire logic [4:0]   cmd_code,
    input  wire logic         cmd_write,
    input  wire logic [W-1:0] cmd_arg,
    input  wire logic         sample_valid,
    input  wire logic [W-1:0] sample_weight,
    input  wire logic         sample_stable,
    input  wire logic [4:0]   fault_flags,
    input  wire logic         autozero_at_start,
    input  wire logic [W-1:0] stored_zero,
    output logic              resp_valid,
    input  wire logic         resp_ready,
    output logic [4:0]        resp_code,
    output logic [2:0]        resp_kind,
    output logic [1:0]        resp_flags,
    output logic [1:0]        resp_unit,
    output logic [W-1:0]      resp_value
);
    localparam int TW = `WCI_TIMER_W;
    localparam int RW = 12 + W;
    localparam int CW = $clog2(DEPTH + 1);
    localparam int KW = $clog2(TICK_CYCLES);

    typedef weigh_cmd_pkg::cmd_t cmd_t;

    function automatic logic is_weight_op(input cmd_t c);
        return c inside {weigh_cmd_pkg::c_weight_stable,
                         weigh_cmd_pkg::c_get_stable_or_dynamic,
                         weigh_cmd_pkg::c_weight_now,
                         weigh_cmd_pkg::c_repeat_weight_now,
                         weigh_cmd_pkg::c_get_net_with_flags,
                         weigh_cmd_pkg::c_repeat_next_stable,
                         weigh_cmd_pkg::c_repeat_on_change};
    endfunction

    function automatic logic is_tare_op(input cmd_t c);
        return c inside {weigh_cmd_pkg::c_offset_stable,
                         weigh_cmd_pkg::c_timed_offset_capture,
                         weigh_cmd_pkg::c_immediate_offset_capture};
    endfunction

    function automatic logic is_ref_op(input cmd_t c);
        return c inside {weigh_cmd_pkg::c_reference_stable,
                         weigh_cmd_pkg::c_timed_reference_capture,
                         weigh_cmd_pkg::c_immediate_reference_capture};
    endfunction

    function automatic logic needs_wait(input cmd_t c);
        return c inside {weigh_cmd_pkg::c_weight_stable,
                         weigh_cmd_pkg::c_get_stable_or_dynamic,
                         weigh_cmd_pkg::c_offset_stable,
                         weigh_cmd_pkg::c_timed_offset_capture,
                         weigh_cmd_pkg::c_reference_stable,
                         weigh_cmd_pkg::c_timed_reference_capture};
    endfunction

    function automatic logic strict_op(input cmd_t c);
        return c inside {weigh_cmd_pkg::c_weight_stable,
                         weigh_cmd_pkg::c_offset_stable,
                         weigh_cmd_pkg::c_reference_stable};
    endfunction

    function automatic logic is_repeat(input cmd_t c);
        return c inside {weigh_cmd_pkg::c_repeat_weight_now,
                         weigh_cmd_pkg::c_repeat_next_stable,
                         weigh_cmd_pkg::c_repeat_on_change};
    endfunction

    function automatic logic [2:0] first_fault(input logic [4:0] f);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 4; i >= 0; i--)
        begin
            if (f[i])
                r = 3'(i + 1);
        end
        return r;
    endfunction

    weigh_cmd_pkg::state_t     state;
    weigh_cmd_pkg::state_t     next_state;
    cmd_t                      op;
    cmd_t                      next_op;
    cmd_t                      cmd_in;
    cmd_t                      fin_op;
    weigh_cmd_pkg::resp_kind_t kind;
    logic [TW-1:0]             timer;
    logic [TW-1:0]             timeout_val;
    logic [KW-1:0]             tick_cnt;
    logic                      tick;
    logic signed [W-1:0]       zero_point;
    logic signed [W-1:0]       tare;
    logic signed [W-1:0]       last_w;
    logic                      last_st;
    logic signed [W-1:0]       sent_w;
    logic                      start_pending;
    logic                      cmd_take;
    logic                      busy;
    logic                      room;
    logic                      fault;
    logic                      legal;
    logic                      timeout_hit;
    logic                      rep_due;
    logic                      fin;
    logic                      fin_st;
    logic                      fin_to;
    logic                      fin_rej;
    logic signed [W-1:0]       fin_w;
    logic signed [W-1:0]       gross_f;
    logic signed [W-1:0]       net_f;
    logic [W-1:0]              err_val;
    logic [W-1:0]              val;
    logic [1:0]                flg;
    logic [1:0]                unit;
    logic                      tare_load;
    logic signed [W-1:0]       new_tare;
    logic                      do_zero;
    logic                      set_to;
    logic [RW-1:0]             push_data;
    logic [CW-1:0]             f_count;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    assign cmd_in   = cmd_t'(cmd_code);
    assign legal    = cmd_code <= 5'(weigh_cmd_pkg::c_cancel);
    assign cmd_take = cmd_valid && cmd_ready;
    assign busy     = state != weigh_cmd_pkg::s_idle;
    assign fault    = |fault_flags;
    assign err_val  = {{(W - 16){1'b0}}, `WCI_ERR_SUFFIX, 5'h00, first_fault(fault_flags)};
    assign gross_f  = fin_w - zero_point;
    assign net_f    = gross_f - tare;
    assign timeout_hit = state == weigh_cmd_pkg::s_wait && timer == '0;
    assign rep_due  = (op == weigh_cmd_pkg::c_repeat_weight_now)
                    || (op == weigh_cmd_pkg::c_repeat_next_stable && sample_stable
                        && sample_weight != sent_w)
                    || (op == weigh_cmd_pkg::c_repeat_on_change
                        && sample_weight != sent_w);

    ////////////////////////////////////////////////////////////////////////////
    // command flow

    always_comb
    begin
        next_state = state;
        next_op    = op;
        fin        = 1'b0;
        fin_op     = op;
        fin_w      = last_w;
        fin_st     = last_st;
        fin_to     = 1'b0;
        fin_rej    = 1'b0;
        if (cmd_take && busy)
        begin
            fin     = 1'b1;
            fin_op  = cmd_in;
            fin_rej = cmd_in != weigh_cmd_pkg::c_cancel;
            if (cmd_in == weigh_cmd_pkg::c_cancel)
                next_state = weigh_cmd_pkg::s_idle;
        end
        else
        begin
            unique case (state)
                weigh_cmd_pkg::s_idle:
                begin
                    if (cmd_take)
                    begin
                        fin_op = cmd_in;
                        if (!legal)
                        begin
                            fin     = 1'b1;
                            fin_rej = 1'b1;
                        end
                        else if (needs_wait(cmd_in))
                        begin
                            next_state = weigh_cmd_pkg::s_wait;
                            next_op    = cmd_in;
                        end
                        else if (is_repeat(cmd_in))
                        begin
                            next_state = weigh_cmd_pkg::s_repeat;
                            next_op    = cmd_in;
                            fin        = cmd_in != weigh_cmd_pkg::c_repeat_next_stable;
                        end
                        else
                            fin = 1'b1;
                    end
                end
                weigh_cmd_pkg::s_wait:
                begin
                    if (room && sample_valid && sample_stable)
                    begin
                        fin        = 1'b1;
                        fin_w      = sample_weight;
                        fin_st     = 1'b1;
                        next_state = weigh_cmd_pkg::s_idle;
                    end
                    else if (room && timeout_hit)
                    begin
                        fin        = 1'b1;
                        fin_to     = strict_op(op);
                        next_state = weigh_cmd_pkg::s_idle;
                    end
                end
                weigh_cmd_pkg::s_repeat:
                begin
                    if (room && fault)
                    begin
                        fin        = 1'b1;
                        next_state = weigh_cmd_pkg::s_idle;
                    end
                    else if (room && sample_valid && rep_due)
                    begin
                        fin    = 1'b1;
                        fin_w  = sample_weight;
                        fin_st = sample_stable;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // answer and action

    always_comb
    begin
        kind      = weigh_cmd_pkg::k_ack;
        val       = '0;
        flg       = {tare != '0, fin_st};
        unit      = `WCI_NO_UNIT;
        tare_load = 1'b0;
        new_tare  = gross_f;
        do_zero   = 1'b0;
        set_to    = 1'b0;
        if (fin_rej)
            kind = weigh_cmd_pkg::k_refused;
        else if (fin_to)
            kind = weigh_cmd_pkg::k_abort;
        else if (is_weight_op(fin_op))
        begin
            if (fault)
            begin
                kind = weigh_cmd_pkg::k_error;
                val  = err_val;
            end
            else
            begin
                kind = weigh_cmd_pkg::k_weight;
                val  = net_f;
                if (fin_op == weigh_cmd_pkg::c_get_net_with_flags)
                    unit = `WCI_UNIT_CODE;
            end
        end
        else if (is_tare_op(fin_op))
        begin
            if (gross_f < 0)
                kind = weigh_cmd_pkg::k_refused;
            else
                tare_load = 1'b1;
        end
        else if (is_ref_op(fin_op))
            do_zero = 1'b1;
        else if (fin_op == weigh_cmd_pkg::c_offset_memory_access)
        begin
            tare_load = cmd_write;
            new_tare  = cmd_arg;
            val       = tare;
        end
        else if (fin_op == weigh_cmd_pkg::c_offset_memory_clear)
        begin
            tare_load = 1'b1;
            new_tare  = '0;
        end
        else if (fin_op == weigh_cmd_pkg::c_general_timeout_setting)
        begin
            set_to = cmd_write;
            val    = W'(timeout_val);
        end
    end

    assign push_data = {fin_op, kind, flg, unit, val};

    ////////////////////////////////////////////////////////////////////////////
    // state

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state     <= weigh_cmd_pkg::s_idle;
            op        <= weigh_cmd_pkg::c_cancel;
            cmd_ready <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            op        <= next_op;
            cmd_ready <= f_count < CW'(DEPTH - 1);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end
        else
        begin
            tick     <= tick_cnt == KW'(TICK_CYCLES - 1);
            tick_cnt <= (tick_cnt == KW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            timer <= '0;
        else if (!busy && next_state == weigh_cmd_pkg::s_wait)
            timer <= timeout_val;
        else if (tick && timer != '0)
            timer <= timer - 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            timeout_val <= `WCI_TIMEOUT_RST;
        else if (fin && !fin_rej && set_to)
            timeout_val <= cmd_arg[TW-1:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            last_w  <= '0;
            last_st <= 1'b0;
            sent_w  <= '0;
        end
        else
        begin
            if (sample_valid)
            begin
                last_w  <= sample_weight;
                last_st <= sample_stable;
            end
            if (fin && kind == weigh_cmd_pkg::k_weight)
                sent_w <= fin_w;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            zero_point    <= '0;
            start_pending <= 1'b1;
        end
        else if (fin && do_zero && kind == weigh_cmd_pkg::k_ack)
            zero_point <= fin_w;
        else if (start_pending && sample_valid)
        begin
            zero_point    <= autozero_at_start ? sample_weight : stored_zero;
            start_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            tare <= '0;
        else if (fin && do_zero && kind == weigh_cmd_pkg::k_ack)
            tare <= '0;
        else if (fin && tare_load && kind == weigh_cmd_pkg::k_ack)
            tare <= new_tare;
    end

    ////////////////////////////////////////////////////////////////////////////
    // response fifo

    resp_fifo #(
        .WIDTH (RW),
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .in_valid  (fin),
        .in_ready  (room),
        .in_data   (push_data),
        .out_valid (resp_valid),
        .out_ready (resp_ready),
        .out_data  ({resp_code, resp_kind, resp_flags, resp_unit, resp_value}),
        .count     (f_count)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    ready_room_a: assert property (cmd_ready |-> room) else $error("ready without room");
    fault_no_weight_a: assert property (fin && fault |-> kind != weigh_cmd_pkg::k_weight) else $error("weight under fault");
    fault_code_a: assert property (fin && kind == weigh_cmd_pkg::k_error |-> val[15:0] == {`WCI_ERR_SUFFIX, 5'h00, first_fault(fault_flags)} && val[2:0] != 3'h0) else $error("bad fault code");
    tare_refuse_a: assert property (fin && is_tare_op(fin_op) && !fin_rej && !fin_to && gross_f < 0 |=> $stable(tare)) else $error("tare taken while negative");
    tare_zeroes_a: assert property (fin && tare_load && is_tare_op(fin_op) && kind == weigh_cmd_pkg::k_ack |=> tare == $past(gross_f)) else $error("tare not stored");
    zero_clears_a: assert property (fin && do_zero && kind == weigh_cmd_pkg::k_ack |=> tare == '0 && zero_point == $past(fin_w)) else $error("zeroing incomplete");
    wait_abort_a: assert property (timeout_hit && room && !cmd_take && !(sample_valid && sample_stable) && strict_op(op) |-> fin && kind == weigh_cmd_pkg::k_abort ##1 !busy) else $error("no abort at timeout");
    wait_dynamic_a: assert property (timeout_hit && room && !cmd_take && !(sample_valid && sample_stable) && op == weigh_cmd_pkg::c_get_stable_or_dynamic && !fault |-> fin && kind == weigh_cmd_pkg::k_weight && !fin_st) else $error("no dynamic fallback");
    cancel_idle_a: assert property (cmd_take && cmd_in == weigh_cmd_pkg::c_cancel |=> state == weigh_cmd_pkg::s_idle) else $error("cancel ignored");
    timeout_set_a: assert property (cmd_take && !busy && cmd_write && cmd_in == weigh_cmd_pkg::c_general_timeout_setting |=> timeout_val == $past(cmd_arg[TW-1:0])) else $error("timeout not set");

    repeat_run_c: cover property (state == weigh_cmd_pkg::s_repeat ##1 fin [*3]);
    abort_seen_c: cover property (fin && kind == weigh_cmd_pkg::k_abort);
    tare_done_c: cover property (fin && tare_load && kind == weigh_cmd_pkg::k_ack);
    fifo_full_c: cover property (!room);

endmodule // weigh_command_interpreter

`default_nettype wire

// File: dv/weigh_host_model.sv
// host model offering commands on the command port
`timescale 1ns/1ps
`default_nettype none
module weigh_host_model (
    input  wire logic        clk_sys,
    input  wire logic        cmd_ready,
    output logic             cmd_valid,
    output logic [4:0]       cmd_code,
    output logic             cmd_write,
    output logic [23:0]      cmd_arg
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code  = 5'h0;
        cmd_write = 1'b0;
        cmd_arg   = 24'h0;
    end
    // offer one command and hold it until the edge that takes it
    task automatic send(input logic [4:0] c, input logic w, input logic [23:0] a);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_code  = c;
        cmd_write = w;
        cmd_arg   = a;
        while (cmd_ready !== 1'b1)
            @(negedge clk_sys);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        cmd_code  = ~c;
        cmd_arg   = ~a;
    endtask
endmodule // weigh_host_model
`default_nettype wire

// File: dv/weigh_command_interpreter_bench.sv
// self-checking bench of the weigh command interpreter
`timescale 1ns/1ps
`default_nettype none
module weigh_command_interpreter_bench;
    logic        clk_sys, reset, cmd_valid, cmd_ready, cmd_write, sample_valid;
    logic        sample_stable, autozero_at_start, resp_valid, resp_ready;
    logic [4:0]  cmd_code, fault_flags, resp_code;
    logic [23:0] cmd_arg, sample_weight, resp_value, stored_zero;
    logic [2:0]  resp_kind;
    logic [1:0]  resp_flags, resp_unit;
    int          fails, tests_run, cyc;

    weigh_command_interpreter #(.W(24), .DEPTH(4), .TICK_CYCLES(10)) weigh_command_interpreter_i (
        .clk_sys(clk_sys), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_arg(cmd_arg),
        .sample_valid(sample_valid), .sample_weight(sample_weight),
        .sample_stable(sample_stable), .fault_flags(fault_flags),
        .autozero_at_start(autozero_at_start), .stored_zero(stored_zero),
        .resp_valid(resp_valid), .resp_ready(resp_ready), .resp_code(resp_code),
        .resp_kind(resp_kind), .resp_flags(resp_flags), .resp_unit(resp_unit),
        .resp_value(resp_value));
    weigh_host_model weigh_host_model_i (
        .clk_sys(clk_sys), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_arg(cmd_arg));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        if (fails == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] g);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic samp(input logic [23:0] w, input logic s);
        @(negedge clk_sys);
        sample_valid  = 1'b1;
        sample_weight = w;
        sample_stable = s;
        @(negedge clk_sys);
        sample_valid  = 1'b0;
        sample_weight = ~w;
    endtask
    task automatic snd(input logic [4:0] c, input logic w, input logic [23:0] a);
        weigh_host_model_i.send(c, w, a);
    endtask
    // kind 7: value only; code and {flags, unit} always checked
    task automatic chk(input logic [2:0] k, input logic [23:0] v, input logic [4:0] c,
                       input logic [3:0] fu);
        int n;
        n = 0;
        while (resp_valid !== 1'b1 && n < 2000)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (k != 3'h7)
            cmp("kind", {21'h0, k}, {21'h0, resp_kind});
        if (k == 3'h1 || k == 3'h2 || k == 3'h7)
            cmp("value", v, resp_value);
        cmp("code", {19'h0, c}, {19'h0, resp_code});
        cmp("flags unit", {20'h0, fu}, {20'h0, resp_flags, resp_unit});
        resp_ready = 1'b1;
        @(negedge clk_sys);
        resp_ready = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_weigh();
        snd(5'h02, 1'b0, 24'h0);
        chk(3'h1, 24'h32, 5'h02, 4'h4);
        snd(5'h04, 1'b0, 24'h0);
        chk(3'h1, 24'h32, 5'h04, 4'h5);
        snd(5'h11, 1'b0, 24'h0);
        chk(3'h4, 24'h0, 5'h11, 4'h4);
    endtask
    task automatic t_tare();
        snd(5'h0B, 1'b0, 24'h0);
        chk(3'h0, 24'h0, 5'h0B, 4'h4);
        snd(5'h02, 1'b0, 24'h0);
        chk(3'h1, 24'h0, 5'h02, 4'hC);
        samp(24'h5A, 1'b1);
        snd(5'h0B, 1'b0, 24'h0);
        chk(3'h4, 24'h0, 5'h0B, 4'hC);
        snd(5'h08, 1'b0, 24'h0);
        chk(3'h7, 24'h32, 5'h08, 4'hC);
        snd(5'h09, 1'b0, 24'h0);
        chk(3'h0, 24'h0, 5'h09, 4'hC);
        snd(5'h08, 1'b1, 24'h14);
        chk(3'h0, 24'h0, 5'h08, 4'h4);
        snd(5'h02, 1'b0, 24'h0);
        chk(3'h1, 24'hFFFFE2, 5'h02, 4'hC);
    endtask
    task automatic t_zero();
        snd(5'h0E, 1'b0, 24'h0);
        chk(3'h0, 24'h0, 5'h0E, 4'hC);
        snd(5'h08, 1'b0, 24'h0);
        chk(3'h7, 24'h0, 5'h08, 4'h4);
        snd(5'h02, 1'b0, 24'h0);
        chk(3'h1, 24'h0, 5'h02, 4'h4);
    endtask
    task automatic t_fault();
        for (int i = 0; i < 5; i++)
        begin
            fault_flags = 5'h1 << i;
            snd(5'h02, 1'b0, 24'h0);
            chk(3'h2, {8'h0, 8'h62, 5'h0, 3'(i + 1)}, 5'h02, 4'h4);
        end
        fault_flags = 5'h0;
    endtask
    task automatic t_wait();
        snd(5'h00, 1'b0, 24'h0);
        samp(24'h82, 1'b0);
        samp(24'h87, 1'b1);
        chk(3'h1, 24'h2D, 5'h00, 4'h4);
        snd(5'h0F, 1'b1, 24'h2);
        chk(3'h0, 24'h0, 5'h0F, 4'h4);
        snd(5'h00, 1'b0, 24'h0);
        chk(3'h3, 24'h0, 5'h00, 4'h4);
        samp(24'h78, 1'b0);
        snd(5'h01, 1'b0, 24'h0);
        chk(3'h1, 24'h1E, 5'h01, 4'h0);
    endtask
    task automatic t_repeat();
        snd(5'h03, 1'b0, 24'h0);
        chk(3'h1, 24'h1E, 5'h03, 4'h0);
        snd(5'h02, 1'b0, 24'h0);
        chk(3'h4, 24'h0, 5'h02, 4'h0);
        samp(24'h8C, 1'b0);
        chk(3'h1, 24'h32, 5'h03, 4'h0);
        snd(5'h10, 1'b0, 24'h0);
        chk(3'h0, 24'h0, 5'h10, 4'h0);
    endtask
    task automatic t_more();
        snd(5'h06, 1'b0, 24'h0);
        chk(3'h1, 24'h32, 5'h06, 4'h0);
        samp(24'h8C, 1'b1);
        samp(24'h91, 1'b0);
        chk(3'h1, 24'h37, 5'h06, 4'h0);
        fault_flags = 5'h02;
        chk(3'h2, 24'h006202, 5'h06, 4'h0);
        fault_flags = 5'h0;
        snd(5'h05, 1'b0, 24'h0);
        samp(24'h96, 1'b0);
        samp(24'hA0, 1'b1);
        chk(3'h1, 24'h46, 5'h05, 4'h4);
        snd(5'h10, 1'b0, 24'h0);
        chk(3'h0, 24'h0, 5'h10, 4'h4);
        snd(5'h07, 1'b0, 24'h0);
        samp(24'hA0, 1'b1);
        chk(3'h0, 24'h0, 5'h07, 4'h4);
        snd(5'h08, 1'b0, 24'h0);
        chk(3'h7, 24'h46, 5'h08, 4'hC);
        snd(5'h0D, 1'b0, 24'h0);
        chk(3'h0, 24'h0, 5'h0D, 4'hC);
        snd(5'h02, 1'b0, 24'h0);
        chk(3'h1, 24'h0, 5'h02, 4'h4);
    endtask
    task automatic t_restart();
        reset             = 1'b1;
        autozero_at_start = 1'b0;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        samp(24'h1E, 1'b1);
        snd(5'h02, 1'b0, 24'h0);
        chk(3'h1, 24'h14, 5'h02, 4'h4);
        snd(5'h0F, 1'b0, 24'h0);
        chk(3'h7, 24'h000BB8, 5'h0F, 4'h4);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever
            #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            close_out();
        end
    end
    initial
    begin
        {fails, tests_run, cyc} = '0;
        {reset, sample_valid, sample_stable, autozero_at_start, resp_ready} = 5'h12;
        sample_weight = 24'h0;
        stored_zero   = 24'h00000A;
        fault_flags   = 5'h0;
        repeat (8) @(negedge clk_sys);
        reset = 1'b0;
        samp(24'h64, 1'b1);
        samp(24'h96, 1'b1);
        t_weigh();
        t_tare();
        t_zero();
        samp(24'h82, 1'b1);
        t_fault();
        t_wait();
        t_repeat();
        t_more();
        t_restart();
        close_out();
    end
endmodule // weigh_command_interpreter_bench
`default_nettype wire
